// file: core/nvm_write_erase_sequencer.sv
/*
  Nonvolatile-memory write/erase sequencer, reached over AHB-Lite.
  Assumes a single AHB-Lite master doing whole-word single transfers and a
  memory array that accepts one-cycle write/erase pulses on hclk.
*/
`timescale 1ns/1ps
`include "nvm_cfg.svh"

module nvm_write_erase_sequencer
  import nvm_pkg::*;
#(
  parameter int WRITE_TIME_US = `EE_WRITE_TIME_US,
  parameter int ERASE_TIME_US = `ROW_ERASE_TIME_US,
  parameter int ROW_WORDS     = 32
) (
  input  wire logic        hclk,         // system clock, 40 MHz
  input  wire logic        hresetn,      // async reset, active low
  input  wire logic        hsel,         // slave select
  input  wire logic [31:0] haddr,        // byte address
  input  wire logic [1:0]  htrans,       // transfer type
  input  wire logic        hwrite,       // write when high
  input  wire logic [2:0]  hsize,        // word only
  input  wire logic [31:0] hwdata,       // write data
  input  wire logic        hready,       // bus ready
  output logic             hreadyout,    // slave ready
  output logic [31:0]      hrdata,       // read data
  output logic             hresp,        // always OKAY
  input  wire logic [15:0] wp_limit,     // program addresses below are protected from row erase
  output logic [15:0]      mem_addr,     // target address
  output logic [7:0]       mem_wdata,    // byte to write
  output logic             mem_region,   // 1: user-ID/EEPROM space
  output logic             mem_ee_write, // EEPROM byte write pulse
  output logic             mem_pgm_write,// program word write pulse
  output logic             mem_row_erase,// row erase pulse
  output logic             cpu_stall,    // CPU held during erase
  output logic             irq           // level interrupt
);

  localparam int WR_CYC = (WRITE_TIME_US * `CLK_FREQ_MHZ < 1) ? 1
                        : WRITE_TIME_US * `CLK_FREQ_MHZ;
  localparam int ER_CYC = (ERASE_TIME_US * `CLK_FREQ_MHZ < 1) ? 1
                        : ERASE_TIME_US * `CLK_FREQ_MHZ;
  localparam logic [15:0] ROW_MASK = 16'(ROW_WORDS - 1);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_ph_r;    // write data phase
  logic        rd_pend_r;  // read wait state
  logic        ok_r;       // address mapped and aligned
  logic [11:0] idx_r;
  logic [31:0] hrdata_r;
  logic [7:0]  rd_mux;
  logic        ahb_go;

  assign ahb_go = hsel && htrans[1] && hready;

  // capture the address phase; reads get one wait state so data is flopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_r   <= 1'b0;
      rd_pend_r <= 1'b0;
      ok_r      <= 1'b0;
      idx_r     <= '0;
    end
    else
    begin
      wr_ph_r   <= ahb_go && hwrite;
      rd_pend_r <= ahb_go && !hwrite;
      if (ahb_go)
      begin
        idx_r <= haddr[13:2];
        ok_r  <= (haddr[31:14] == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  assign hreadyout = !rd_pend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  logic [7:0]  wdata;
  logic        wr_key, wr_ctl, wr_adrl, wr_adrh, wr_data, wr_iclr, wr_ien;

  assign wdata   = hwdata[7:0];
  assign wr_key  = wr_ph_r && ok_r && (idx_r == `IDX_KEY);
  assign wr_ctl  = wr_ph_r && ok_r && (idx_r == `IDX_CTL);
  assign wr_adrl = wr_ph_r && ok_r && (idx_r == `IDX_ADRL);
  assign wr_adrh = wr_ph_r && ok_r && (idx_r == `IDX_ADRH);
  assign wr_data = wr_ph_r && ok_r && (idx_r == `IDX_DATA);
  assign wr_iclr = wr_ph_r && ok_r && (idx_r == `IDX_ICLR);
  assign wr_ien  = wr_ph_r && ok_r && (idx_r == `IDX_IEN);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]  ctl_r;
  logic [7:0]  adrl_r, adrh_r, data_r;
  logic [1:0]  stat_r, ien_r;
  logic [15:0] addr_w;
  key_state_t  key_st_r;
  op_state_t   op_r;
  logic        tmr_expire;
  logic        attempt, prot, launch;

  assign addr_w = {adrh_r, adrl_r};

  // a start request: control write with start and write enable, no op running
  assign attempt = wr_ctl && wdata[`CTL_START] && wdata[`CTL_WRITE_ENABLE_BIT] && (op_r == OP_IDLE);
  assign prot    = wdata[`CTL_ERASE] && !wdata[`CTL_REGION] && (addr_w < wp_limit);
  assign launch  = attempt && (key_st_r == KEY_ARMED) && !prot;

  // address, data and interrupt enable; address and data held while an op runs so the target
  // cannot move under the array, interrupt enable writable at any time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adrl_r <= `BYTE_RST;
      adrh_r <= `BYTE_RST;
      data_r <= `BYTE_RST;
      ien_r  <= `ST_RST;
    end
    else
    begin
      if (wr_adrl && op_r == OP_IDLE)
        adrl_r <= wdata;
      if (wr_adrh && op_r == OP_IDLE)
        adrh_r <= wdata;
      if (wr_data && op_r == OP_IDLE)
        data_r <= wdata;
      if (wr_ien)
        ien_r <= wdata[1:0];
    end
  end

  // control register; start only rises on a keyed launch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctl_r <= `CTL_RST;
    else if (op_r == OP_IDLE)
    begin
      if (wr_ctl)
      begin
        ctl_r[`CTL_WRITE_ENABLE_BIT]   <= wdata[`CTL_WRITE_ENABLE_BIT];
        ctl_r[`CTL_ERASE]  <= wdata[`CTL_ERASE];
        ctl_r[`CTL_REGION] <= wdata[`CTL_REGION];
        ctl_r[`CTL_START]  <= launch;
      end
    end
    else
    begin
      if (tmr_expire)
        ctl_r[`CTL_START] <= 1'b0;
      if (wr_ctl)
        ctl_r[`CTL_WRITE_ENABLE_BIT] <= wdata[`CTL_WRITE_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // unlock key tracking
  // ----------------------------------------------------------------
  // tracking starts on key write; any other write breaks the chain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_st_r <= KEY_IDLE;
    else if (wr_ph_r)
    begin
      if (wr_key && wdata == `KEY_FIRST)
        key_st_r <= KEY_GOT1;
      else if (wr_key && wdata == `KEY_SECOND && key_st_r == KEY_GOT1)
        key_st_r <= KEY_ARMED;
      else
        key_st_r <= KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // operation sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      op_r <= OP_IDLE;
    else
    begin
      case (op_r)
        OP_IDLE:
        begin
          if (launch)
          begin
            if (wdata[`CTL_ERASE])
              op_r <= OP_ERASE;
            else if (wdata[`CTL_REGION])
              op_r <= OP_EE;
            else
              op_r <= OP_PGM;
          end
        end
        default:
        begin
          if (tmr_expire)
            op_r <= OP_IDLE;
        end
      endcase
    end
  end

  nvm_op_timer #(
    .W (16)
  ) nvm_op_timer_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (launch),
    .count   (wdata[`CTL_ERASE] ? 16'(ER_CYC) : 16'(WR_CYC)),
    .busy    (),
    .expire  (tmr_expire)
  );

  // memory strobes and target; flopped so the array sees clean pulses
  logic [15:0] mem_addr_r;
  logic [7:0]  mem_wdata_r;
  logic        mem_region_r, ee_wr_r, pgm_wr_r, row_er_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_addr_r   <= '0;
      mem_wdata_r  <= `BYTE_RST;
      mem_region_r <= 1'b0;
      ee_wr_r      <= 1'b0;
      pgm_wr_r     <= 1'b0;
      row_er_r     <= 1'b0;
    end
    else
    begin
      ee_wr_r  <= launch && !wdata[`CTL_ERASE] && wdata[`CTL_REGION];
      pgm_wr_r <= launch && !wdata[`CTL_ERASE] && !wdata[`CTL_REGION];
      row_er_r <= launch && wdata[`CTL_ERASE];
      if (launch)
      begin
        mem_region_r <= wdata[`CTL_REGION];
        // byte from data register, array erases it itself
        mem_wdata_r  <= data_r;
        if (wdata[`CTL_ERASE])
          mem_addr_r <= addr_w & ~ROW_MASK;
        else if (wdata[`CTL_REGION])
          mem_addr_r <= addr_w - `EE_BASE;
        else
          mem_addr_r <= addr_w;
      end
    end
  end

  assign mem_addr      = mem_addr_r;
  assign mem_wdata     = mem_wdata_r;
  assign mem_region    = mem_region_r;
  assign mem_ee_write  = ee_wr_r;
  assign mem_pgm_write = pgm_wr_r;
  assign mem_row_erase = row_er_r;
  // CPU held for the whole erase
  assign cpu_stall     = (op_r == OP_ERASE);

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  logic [1:0] st_set;

  // done flag on any completion, enable not consulted
  assign st_set = {attempt && prot && key_st_r == KEY_ARMED, tmr_expire};

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_r <= `ST_RST;
    else
      stat_r <= (stat_r & ~(wr_iclr ? wdata[1:0] : 2'h0)) | st_set;
  end

  assign irq = |(stat_r & ien_r);

  // read mux; key and clear registers read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (idx_r == `IDX_CTL)
      rd_mux = {4'h0, ctl_r};
    else if (idx_r == `IDX_ADRL)
      rd_mux = adrl_r;
    else if (idx_r == `IDX_ADRH)
      rd_mux = adrh_r;
    else if (idx_r == `IDX_DATA)
      rd_mux = data_r;
    else if (idx_r == `IDX_STAT)
      rd_mux = {6'h00, stat_r};
    else if (idx_r == `IDX_IEN)
      rd_mux = {6'h00, ien_r};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (rd_pend_r)
      hrdata_r <= ok_r ? {24'h000000, rd_mux} : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_launch_keyed;
    (op_r != OP_IDLE) && ($past(op_r) == OP_IDLE) |-> $past(key_st_r) == KEY_ARMED;
  endproperty
  a_launch_keyed: assert property (p_launch_keyed) else $error("op began unkeyed");

  property p_key_first;
    wr_key && (wdata == `KEY_FIRST) |=> key_st_r == KEY_GOT1;
  endproperty
  a_key_first: assert property (p_key_first) else $error("first key not tracked");

  property p_no_unkeyed;
    wr_ctl && wdata[`CTL_START] && (op_r == OP_IDLE) && (key_st_r != KEY_ARMED)
      |=> (op_r == OP_IDLE) && !ctl_r[`CTL_START];
  endproperty
  a_no_unkeyed: assert property (p_no_unkeyed) else $error("unkeyed start took");

  property p_ee_data;
    mem_ee_write |-> (mem_wdata == $past(data_r)) && cpu_stall == 1'b0;
  endproperty
  a_ee_data: assert property (p_ee_data) else $error("ee byte mismatch");

  property p_ee_done;
    tmr_expire && (op_r == OP_EE) |=> !ctl_r[`CTL_START] && stat_r[`ST_DONE]
      && (op_r == OP_IDLE);
  endproperty
  a_ee_done: assert property (p_ee_done) else $error("ee completion wrong");

  property p_start_held;
    (op_r != OP_IDLE) && !tmr_expire |=> ctl_r[`CTL_START];
  endproperty
  a_start_held: assert property (p_start_held) else $error("start dropped early");

  property p_write_enable_bit_kept;
    tmr_expire && !wr_ctl |=> ctl_r[`CTL_WRITE_ENABLE_BIT] == $past(ctl_r[`CTL_WRITE_ENABLE_BIT]);
  endproperty
  a_write_enable_bit_kept: assert property (p_write_enable_bit_kept) else $error("write_enable_bit changed");

  property p_protect;
    attempt && prot |=> (!ctl_r[`CTL_START] && !mem_row_erase)[*2];
  endproperty
  a_protect: assert property (p_protect) else $error("protected erase ran");

  property p_stall;
    $rose(mem_row_erase) |-> cpu_stall [*8];
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not stalled");

  property p_flag_free;
    tmr_expire && !ien_r[`ST_DONE] && !wr_ien
      |=> stat_r[`ST_DONE] && (!irq || ien_r[`ST_WPERR]);
  endproperty
  a_flag_free: assert property (p_flag_free) else $error("done flag gated");

  property p_key_reads_zero;
    rd_pend_r && ok_r && (idx_r == `IDX_KEY) |=> hrdata == 32'h00000000 && hreadyout;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");

endmodule

// file: core/nvm_cfg.svh
/*
  Constants of the nonvolatile-memory write/erase sequencer: register word
  indices, field positions, reset values, key bytes and operation times.
  Assumes it is included by bare name from the design files.
*/
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// register word indices; byte address is four times the index
`define IDX_KEY      12'h81F
`define IDX_CTL      12'h820
`define IDX_ADRL     12'h821
`define IDX_ADRH     12'h822
`define IDX_DATA     12'h823
`define IDX_STAT     12'h824
`define IDX_ICLR     12'h825
`define IDX_IEN      12'h826

// control register fields
`define CTL_START    0
`define CTL_WRITE_ENABLE_BIT     1
`define CTL_ERASE    2
`define CTL_REGION   3

// status / clear / enable fields
`define ST_DONE      0
`define ST_WPERR     1

// reset values
`define CTL_RST      4'h0
`define BYTE_RST     8'h00
`define ST_RST       2'h0

// unlock key bytes and data-EEPROM address offset
`define KEY_FIRST    8'h55
`define KEY_SECOND   8'hAA
`define EE_BASE      16'h7000

// operation times in microseconds, system clock in MHz
`define EE_WRITE_TIME_US   4
`define ROW_ERASE_TIME_US  2
`define CLK_FREQ_MHZ       40

`endif

// file: core/nvm_pkg.sv
/*
  Types shared by the sequencer: key tracker and operation states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nvm_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} key_state_t;

  typedef enum logic [1:0] {OP_IDLE, OP_EE, OP_PGM, OP_ERASE} op_state_t;

endpackage

// file: core/nvm_op_timer.sv
/*
  Down-counter that times one memory operation and pulses when it ends.
  Assumes load is a one-cycle pulse on hclk and count is at least one.
*/
`timescale 1ns/1ps

module nvm_op_timer #(
  parameter int W = 16
) (
  input  wire logic         hclk,    // system clock
  input  wire logic         hresetn, // async reset, active low
  input  wire logic         load,    // start timing
  input  wire logic [W-1:0] count,   // cycles to run
  output logic              busy,    // operation in progress
  output logic              expire   // one-cycle end pulse
);

  logic [W-1:0] cnt_r;
  logic         expire_r;

  // count down; a new load while busy restarts the count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end
    else
    begin
      expire_r <= (cnt_r == W'(1)) && !load;
      if (load)
        cnt_r <= count;
      else if (cnt_r != '0)
        cnt_r <= cnt_r - W'(1);
    end
  end

  assign busy   = (cnt_r != '0);
  assign expire = expire_r;

endmodule

// file: test/tb_nvm_write_erase_sequencer.sv
/*
  Self-checking bench for the write/erase sequencer: register traffic over
  AHB-Lite, keyed EEPROM writes, row erases, protection and the interrupt.
  Assumes the core/ files are compiled first and core/ is on the include path.
*/
`timescale 1ns/1ps
`include "nvm_cfg.svh"

module tb_nvm_write_erase_sequencer;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  logic [15:0] wp_limit;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_region;
  logic        mem_ee_write;
  logic        mem_pgm_write;
  logic        mem_row_erase;
  logic        cpu_stall;
  logic        irq;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          ee_cnt = 0;
  int          er_cnt = 0;
  int          pgm_cnt = 0;
  int          stall_cnt = 0;
  int          cyc = 0;
  logic [15:0] last_addr;
  logic [7:0]  last_data;
  logic        last_reg;
  logic [31:0] rnd = 32'h0000_0B79;

  // short operation times keep each op at 40 cycles
  nvm_write_erase_sequencer #(.WRITE_TIME_US(1), .ERASE_TIME_US(1), .ROW_WORDS(32))
    nvm_write_erase_sequencer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wp_limit(wp_limit),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_region(mem_region),
    .mem_ee_write(mem_ee_write), .mem_pgm_write(mem_pgm_write),
    .mem_row_erase(mem_row_erase), .cpu_stall(cpu_stall), .irq(irq));

  // 40 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // memory-side monitor; also runs the hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (mem_ee_write === 1'b1 || mem_row_erase === 1'b1 || mem_pgm_write === 1'b1)
    begin
      last_addr <= mem_addr;
      last_data <= mem_wdata;
      last_reg  <= mem_region;
    end
    if (mem_ee_write === 1'b1) ee_cnt <= ee_cnt + 1;
    if (mem_row_erase === 1'b1) er_cnt <= er_cnt + 1;
    if (mem_pgm_write === 1'b1) pgm_cnt <= pgm_cnt + 1;
    if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // sample at the falling edge so the rising edge never races the flops
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  task automatic bus_write(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] v;
    hsel   <= 1'b1;
    haddr  <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_rdy(v);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(v);
  endtask

  task automatic bus_read(input logic [11:0] idx, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    wait_rdy(d);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    wait_rdy(d);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus_read(idx, v);
    chk(name, exp, v);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // address, data, optional key pair, then the control write
  task automatic do_op(input logic [7:0] ctl, input logic [15:0] adr,
                       input logic [7:0] dat, input bit keyed);
    bus_write(`IDX_ADRL, {24'h0, adr[7:0]});
    bus_write(`IDX_ADRH, {24'h0, adr[15:8]});
    bus_write(`IDX_DATA, {24'h0, dat});
    if (keyed)
    begin
      bus_write(`IDX_KEY, {24'h0, `KEY_FIRST});
      bus_write(`IDX_KEY, {24'h0, `KEY_SECOND});
    end
    bus_write(`IDX_CTL, {24'h0, ctl});
  endtask

  task automatic wait_done;
    logic [31:0] v;
    int n;
    v = 32'h1;
    n = 0;
    while (v[0] !== 1'b0 && n < 200)
    begin
      bus_read(`IDX_CTL, v);
      n++;
    end
    chk("start_cleared", 32'h0, {31'h0, v[0]});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [15:0] adr;
    logic [7:0]  dat;
    logic [7:0]  ctl;
    int          e0;
    int          s0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wp_limit = 16'h0800;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values of every register and of an unmapped word
    for (int i = 12'h81F; i <= 12'h826; i++)
      rd_chk("reset_value", 12'(i), 32'h0);
    rd_chk("unmapped", 12'h000, 32'h0);
    // key register keeps nothing readable
    bus_write(`IDX_KEY, {24'h0, `KEY_FIRST});
    rd_chk("key_read", `IDX_KEY, 32'h0);
    bus_write(`IDX_IEN, 32'h1);
    // start with no key, then with a broken chain: nothing launches
    e0 = ee_cnt;
    do_op(8'h0B, `EE_BASE, 8'h5A, 1'b0);
    rd_chk("ctl_nokey", `IDX_CTL, 32'h0A);
    bus_write(`IDX_KEY, {24'h0, `KEY_FIRST});
    bus_write(`IDX_DATA, 32'h11);
    bus_write(`IDX_KEY, {24'h0, `KEY_SECOND});
    bus_write(`IDX_CTL, 32'h0B);
    rd_chk("ctl_broken", `IDX_CTL, 32'h0A);
    chk("ee_none", e0, ee_cnt);
    // keyed EEPROM writes with random address and data
    for (int i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      adr = `EE_BASE + {8'h0, rnd[7:0]};
      dat = rnd[15:8];
      e0 = ee_cnt;
      s0 = stall_cnt;
      do_op(8'h0B, adr, dat, 1'b1);
      if (i == 0)
      begin
        bus_write(`IDX_CTL, 32'h0A);
        rd_chk("ctl_clear_ignored", `IDX_CTL, 32'h0B);
      end
      wait_done();
      chk("ee_pulses", e0 + 1, ee_cnt);
      chk("ee_addr", {16'h0, adr - `EE_BASE}, {16'h0, last_addr});
      chk("ee_data", {24'h0, dat}, {24'h0, last_data});
      chk("ee_region", 32'h1, {31'h0, last_reg});
      chk("ee_no_stall", s0, stall_cnt);
      rd_chk("ctl_after_ee", `IDX_CTL, 32'h0A);
      rd_chk("status_done", `IDX_STAT, 32'h1);
      chk("irq_on", 32'h1, {31'h0, irq});
      bus_write(`IDX_ICLR, 32'h1);
      rd_chk("status_clr", `IDX_STAT, 32'h0);
      chk("irq_off", 32'h0, {31'h0, irq});
    end
    // row erases of program and user-ID space with the interrupt masked
    bus_write(`IDX_IEN, 32'h0);
    for (int j = 0; j < 2; j++)
    begin
      rnd = xs(rnd);
      ctl = (j == 0) ? 8'h07 : 8'h0F;
      adr = 16'h1000 | {4'h0, rnd[11:0]};
      e0 = er_cnt;
      s0 = stall_cnt;
      do_op(ctl, adr, rnd[23:16], 1'b1);
      wait_done();
      chk("er_pulses", e0 + 1, er_cnt);
      chk("er_row_addr", {16'h0, adr & 16'hFFE0}, {16'h0, last_addr});
      chk("er_region", j, {31'h0, last_reg});
      chk("er_stall", 32'h1, {31'h0, (stall_cnt - s0) >= 40});
      rd_chk("ctl_after_er", `IDX_CTL, {24'h0, ctl & 8'hFE});
      rd_chk("data_kept", `IDX_DATA, {24'h0, rnd[23:16]});
      rd_chk("status_masked", `IDX_STAT, 32'h1);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus_write(`IDX_ICLR, 32'h1);
      // program word into the row just erased: one write pulse, no erase
      if (j == 0)
      begin
        s0 = er_cnt;
        e0 = pgm_cnt;
        do_op(8'h03, adr, rnd[31:24], 1'b1);
        wait_done();
        chk("pgm_pulses", e0 + 1, pgm_cnt);
        chk("pgm_addr", {16'h0, adr}, {16'h0, last_addr});
        chk("pgm_data", {24'h0, rnd[31:24]}, {24'h0, last_data});
        chk("pgm_no_erase", s0, er_cnt);
        bus_write(`IDX_ICLR, 32'h1);
      end
    end
    // erase of a protected program address is refused
    rnd = xs(rnd);
    e0 = er_cnt;
    do_op(8'h07, {5'h0, rnd[10:0]}, 8'h00, 1'b1);
    rd_chk("ctl_protected", `IDX_CTL, 32'h06);
    rd_chk("status_protected", `IDX_STAT, 32'h2);
    chk("er_none", e0, er_cnt);
    finish_test();
  end
endmodule
